// ---- logic/adc_seq_ctrl.sv ----
// Sequencer, arbitration, averaging and result queue control for the 10-bit converter
`timescale 1ns/1ps
`include "adc_seq_map.svh"

module adc_seq_ctrl (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Peripheral trigger events
  input wire logic [3:0] periph_trig_in,
  // Converter core
  output adc_seq_pkg::conv_req_t conv_req_out,
  input wire logic conv_done_in,
  input wire logic [9:0] conv_data_in,
  // Interrupt lines to the controller
  output logic [3:0] irq_out
);

  // Control registers
  logic [3:0] sequencer_activation_r;
  logic [3:0] irq_mask_r;
  logic [3:0] raw_irq_status_r;
  logic [3:0] overflow_flags_r;
  logic [3:0] underflow_flags_r;
  logic [15:0] trigger_source_select_r;
  logic [7:0] sequencer_priority_r;
  logic [2:0] averaging_control_r;
  logic [31:0] step_input_select_r [4];
  logic [31:0] step_control_flags_r [4];
  logic [3:0] pend_r;

  // Result queues
  logic [9:0] queue_mem_r [4][8];
  logic [2:0] head_r [4];
  logic [2:0] tail_r [4];
  logic [3:0] count_r [4];

  // Sequencer engine
  adc_seq_pkg::seq_state_t state_r;
  logic [1:0] cur_seq_r;
  logic [2:0] step_r;
  logic [6:0] avg_cnt_r;
  logic [15:0] acc_r;
  adc_seq_pkg::conv_req_t conv_req_r;
  logic [31:0] rdata_r;
  logic [3:0] irq_r;

  // Register decode
  wire hit_act = (addr_in == `ADC_OFF_ACTIVATION);
  wire hit_raw = (addr_in == `ADC_OFF_RAW_IRQ);
  wire hit_mask = (addr_in == `ADC_OFF_IRQ_MASK);
  wire hit_isc = (addr_in == `ADC_OFF_MASKED_IRQ);
  wire hit_ovf = (addr_in == `ADC_OFF_OVERFLOW);
  wire hit_trig = (addr_in == `ADC_OFF_TRIG_SELECT);
  wire hit_udf = (addr_in == `ADC_OFF_UNDERFLOW);
  wire hit_pri = (addr_in == `ADC_OFF_PRIORITY);
  wire hit_kick = (addr_in == `ADC_OFF_SW_KICK);
  wire hit_avg = (addr_in == `ADC_OFF_AVERAGING);
  wire wr_isc = wr_in & hit_isc;
  wire wr_ovf = wr_in & hit_ovf;
  wire wr_udf = wr_in & hit_udf;
  wire [3:0] sw_start_bits = (wr_in & hit_kick) ? wdata_in[3:0] : 4'h0;
  wire [3:0] masked_status = raw_irq_status_r & irq_mask_r;

  // Per-sequencer decode and queue terms
  logic [3:0] hit_input;
  logic [3:0] hit_ctrl;
  logic [3:0] hit_port;
  logic [3:0] hit_status;
  logic [3:0] q_empty;
  logic [3:0] q_full;
  logic [3:0] q_pop;
  logic [3:0] q_push;
  logic [3:0] q_underflow;
  logic [3:0] q_overflow;
  logic [3:0] trig_hit;
  logic [31:0] depth_mask [4];
  logic [31:0] status_word [4];

  // Engine terms
  wire storing = (state_r == adc_seq_pkg::ST_STORE);
  wire [3:0] step_ctl = step_control_flags_r[cur_seq_r][{step_r, 2'b00} +: 4];
  wire [3:0] step_sel = step_input_select_r[cur_seq_r][{step_r, 2'b00} +: 4];
  wire [2:0] avg_shift = (averaging_control_r > `ADC_AVG_MAX_SHIFT) ? `ADC_AVG_MAX_SHIFT : averaging_control_r;
  wire [6:0] avg_goal = 7'((8'h01 << avg_shift) - 8'h01);
  wire avg_last = (avg_cnt_r == avg_goal);
  wire [15:0] acc_sum = acc_r + {6'h00, conv_data_in};
  wire [15:0] acc_mean = acc_r >> avg_shift;
  wire [3:0] cur_depth = adc_seq_pkg::seq_depth(int'(cur_seq_r));
  wire seq_last = step_ctl[`ADC_CTL_END] | ({1'b0, step_r} == 4'(cur_depth - 4'h1));
  wire [3:0] eligible = pend_r & sequencer_activation_r;

  genvar s;
  generate
    for (s = 0; s < 4; s = s + 1) begin : g_seq
      localparam logic [11:0] BASE = 12'(`ADC_OFF_SEQ_BASE + s * `ADC_OFF_SEQ_STRIDE);
      localparam logic [3:0] DEPTH = adc_seq_pkg::seq_depth(s);
      wire [3:0] code = trigger_source_select_r[4 * s +: 4];
      assign hit_input[s] = (addr_in == BASE + `ADC_OFF_STEP_INPUT);
      assign hit_ctrl[s] = (addr_in == BASE + `ADC_OFF_STEP_CTRL);
      assign hit_port[s] = (addr_in == BASE + `ADC_OFF_QUEUE_PORT);
      assign hit_status[s] = (addr_in == BASE + `ADC_OFF_QUEUE_STATUS);
      assign depth_mask[s] = (DEPTH == 4'h8) ? 32'hffff_ffff : ((32'h1 << {DEPTH, 2'b00}) - 32'h1);
      assign q_empty[s] = (count_r[s] == 4'h0);
      assign q_full[s] = (count_r[s] == DEPTH);
      assign q_pop[s] = rd_in & hit_port[s] & ~q_empty[s];
      assign q_underflow[s] = rd_in & hit_port[s] & q_empty[s];
      assign q_push[s] = storing & (cur_seq_r == 2'(s)) & ~q_full[s];
      assign q_overflow[s] = storing & (cur_seq_r == 2'(s)) & q_full[s];
      assign status_word[s] = {19'h0, q_full[s], 3'h0, q_empty[s], 1'b0, head_r[s], 1'b0, tail_r[s]};
      assign trig_hit[s] = ((code == `ADC_TRIG_PROCESSOR) & sw_start_bits[s]) |
                           (code == `ADC_TRIG_ALWAYS) |
                           ((code != `ADC_TRIG_PROCESSOR) & (code <= `ADC_TRIG_PERIPH_LAST) &
                            periph_trig_in[2'(code - 4'h1)]);

      // Tail is written by the engine, head advances on each read of the port while the queue holds data
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          head_r[s] <= 3'h0;
          tail_r[s] <= 3'h0;
          count_r[s] <= 4'h0;
        end else begin
          if (q_push[s]) begin
            tail_r[s] <= ({1'b0, tail_r[s]} == DEPTH - 4'h1) ? 3'h0 : tail_r[s] + 3'h1;
          end
          if (q_pop[s]) begin
            head_r[s] <= ({1'b0, head_r[s]} == DEPTH - 4'h1) ? 3'h0 : head_r[s] + 3'h1;
          end
          count_r[s] <= count_r[s] + {3'h0, q_push[s]} - {3'h0, q_pop[s]};
        end
      end

      always_ff @(posedge clk_in) begin
        if (q_push[s]) begin
          queue_mem_r[s][tail_r[s]] <= acc_mean[9:0];
        end
      end
    end
  endgenerate

  // Fixed priority: the lowest value among eligible sequencers wins
  logic grant_v;
  logic [1:0] grant_seq;
  always_comb begin
    grant_v = 1'b0;
    grant_seq = 2'h0;
    for (int lvl = 3; lvl >= 0; lvl--) begin
      for (int q = 3; q >= 0; q--) begin
        if (eligible[q] && (sequencer_priority_r[2 * q +: 2] == 2'(lvl))) begin
          grant_v = 1'b1;
          grant_seq = 2'(q);
        end
      end
    end
  end
  wire take = (state_r == adc_seq_pkg::ST_IDLE) & grant_v;

  // Read data path
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0;
    if (hit_act) rdata_nxt = {28'h0, sequencer_activation_r};
    if (hit_raw) rdata_nxt = {28'h0, raw_irq_status_r};
    if (hit_mask) rdata_nxt = {28'h0, irq_mask_r};
    if (hit_isc) rdata_nxt = {28'h0, masked_status};
    if (hit_ovf) rdata_nxt = {28'h0, overflow_flags_r};
    if (hit_trig) rdata_nxt = {16'h0, trigger_source_select_r};
    if (hit_udf) rdata_nxt = {28'h0, underflow_flags_r};
    if (hit_pri) begin
      rdata_nxt = {18'h0, sequencer_priority_r[7:6], 2'h0, sequencer_priority_r[5:4],
                   2'h0, sequencer_priority_r[3:2], 2'h0, sequencer_priority_r[1:0]};
    end
    if (hit_avg) rdata_nxt = {29'h0, averaging_control_r};
    for (int q = 0; q < 4; q++) begin
      if (hit_input[q]) rdata_nxt = step_input_select_r[q];
      if (hit_ctrl[q]) rdata_nxt = step_control_flags_r[q];
      if (hit_port[q]) rdata_nxt = {22'h0, queue_mem_r[q][head_r[q]]};
      if (hit_status[q]) rdata_nxt = status_word[q];
    end
  end

  // Software-written configuration; each register has its own short process
  wire wr_act = wr_in & hit_act;
  wire wr_mask = wr_in & hit_mask;
  wire wr_trig = wr_in & hit_trig;
  wire wr_pri = wr_in & hit_pri;
  wire wr_avg = wr_in & hit_avg;
  wire [7:0] pri_packed = {wdata_in[13:12], wdata_in[9:8], wdata_in[5:4], wdata_in[1:0]};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sequencer_activation_r <= 4'h0;
    end else if (wr_act) begin
      sequencer_activation_r <= wdata_in[3:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_r <= 4'h0;
    end else if (wr_mask) begin
      irq_mask_r <= wdata_in[3:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trigger_source_select_r <= 16'h0;
    end else if (wr_trig) begin
      trigger_source_select_r <= wdata_in[15:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sequencer_priority_r <= `ADC_RST_PRIORITY;
    end else if (wr_pri) begin
      sequencer_priority_r <= pri_packed;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      averaging_control_r <= 3'h0;
    end else if (wr_avg) begin
      averaging_control_r <= wdata_in[2:0];
    end
  end

  // Nibbles past a sequencer's depth stay zero; repeats of one input are allowed
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int q = 0; q < 4; q++) begin
        step_input_select_r[q] <= 32'h0;
        step_control_flags_r[q] <= (q == 3) ? `ADC_RST_CTRL3 : `ADC_RST_CTRL;
      end
    end else if (wr_in) begin
      for (int q = 0; q < 4; q++) begin
        if (hit_input[q]) step_input_select_r[q] <= wdata_in & depth_mask[q];
        if (hit_ctrl[q]) step_control_flags_r[q] <= wdata_in & depth_mask[q];
      end
    end
  end

  // Hardware-set flags: a set in the same cycle as a clear wins
  wire [3:0] irq_set = (storing & step_ctl[`ADC_CTL_IE]) ? (4'h1 << cur_seq_r) : 4'h0;
  wire [3:0] raw_clr = wr_isc ? wdata_in[3:0] : 4'h0;
  wire [3:0] ovf_clr = wr_ovf ? wdata_in[3:0] : 4'h0;
  wire [3:0] udf_clr = wr_udf ? wdata_in[3:0] : 4'h0;
  wire [3:0] pend_clr = take ? (4'h1 << grant_seq) : 4'h0;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      raw_irq_status_r <= 4'h0;
      overflow_flags_r <= 4'h0;
      underflow_flags_r <= 4'h0;
      pend_r <= 4'h0;
      irq_r <= 4'h0;
    end else begin
      raw_irq_status_r <= (raw_irq_status_r & ~raw_clr) | irq_set;
      overflow_flags_r <= (overflow_flags_r & ~ovf_clr) | q_overflow;
      underflow_flags_r <= (underflow_flags_r & ~udf_clr) | q_underflow;
      // A disabled sequencer forgets its trigger; an always trigger re-arms every cycle
      pend_r <= ((pend_r & ~pend_clr) | trig_hit) & sequencer_activation_r;
      irq_r <= masked_status;
    end
  end

  // Step engine, clocked by the converter clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= adc_seq_pkg::ST_IDLE;
      cur_seq_r <= 2'h0;
      step_r <= 3'h0;
      avg_cnt_r <= 7'h0;
      acc_r <= 16'h0;
      conv_req_r <= '0;
    end else begin
      conv_req_r.start <= 1'b0;
      case (state_r)
        adc_seq_pkg::ST_IDLE: begin
          if (grant_v) begin
            cur_seq_r <= grant_seq;
            step_r <= 3'h0;
            avg_cnt_r <= 7'h0;
            acc_r <= 16'h0;
            state_r <= adc_seq_pkg::ST_ISSUE;
          end
        end
        adc_seq_pkg::ST_ISSUE: begin
          conv_req_r.start <= 1'b1;
          conv_req_r.diff <= step_ctl[`ADC_CTL_DIFF];
          conv_req_r.temp <= step_ctl[`ADC_CTL_TEMP];
          if (step_ctl[`ADC_CTL_DIFF]) begin
            // Only pairs 0 to 3 exist, so the upper select bits are ignored
            conv_req_r.pos_chan <= {1'b0, step_sel[1:0], 1'b0};
            conv_req_r.neg_chan <= {1'b0, step_sel[1:0], 1'b1};
          end else begin
            conv_req_r.pos_chan <= step_sel;
            conv_req_r.neg_chan <= 4'h0;
          end
          state_r <= adc_seq_pkg::ST_WAIT;
        end
        adc_seq_pkg::ST_WAIT: begin
          // Core codes arrive offset coded for differential steps, 0x000-0x3ff either way
          if (conv_done_in) begin
            acc_r <= acc_sum;
            if (avg_last) begin
              state_r <= adc_seq_pkg::ST_STORE;
            end else begin
              avg_cnt_r <= avg_cnt_r + 7'h1;
              state_r <= adc_seq_pkg::ST_ISSUE;
            end
          end
        end
        adc_seq_pkg::ST_STORE: begin
          avg_cnt_r <= 7'h0;
          acc_r <= 16'h0;
          if (seq_last) begin
            state_r <= adc_seq_pkg::ST_IDLE;
          end else begin
            step_r <= step_r + 3'h1;
            state_r <= adc_seq_pkg::ST_ISSUE;
          end
        end
        default: state_r <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rd_in ? rdata_nxt : 32'h0;
    end
  end

  assign rdata_out = rdata_r;
  assign conv_req_out = conv_req_r;
  assign irq_out = irq_r;

endmodule // adc_seq_ctrl

// ---- logic/adc_seq_map.svh ----
// Register offsets, field positions, reset values and codes of the sequencer control block
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

`define ADC_OFF_ACTIVATION   12'h000
`define ADC_OFF_RAW_IRQ      12'h004
`define ADC_OFF_IRQ_MASK     12'h008
`define ADC_OFF_MASKED_IRQ   12'h00c
`define ADC_OFF_OVERFLOW     12'h010
`define ADC_OFF_TRIG_SELECT  12'h014
`define ADC_OFF_UNDERFLOW    12'h018
`define ADC_OFF_PRIORITY     12'h020
`define ADC_OFF_SW_KICK      12'h028
`define ADC_OFF_AVERAGING    12'h030
`define ADC_OFF_SEQ_BASE     12'h040
`define ADC_OFF_SEQ_STRIDE   12'h020
`define ADC_OFF_STEP_INPUT   12'h000
`define ADC_OFF_STEP_CTRL    12'h004
`define ADC_OFF_QUEUE_PORT   12'h008
`define ADC_OFF_QUEUE_STATUS 12'h00c

`define ADC_RST_PRIORITY     8'he4
`define ADC_RST_CTRL3        32'h0000_0002
`define ADC_RST_CTRL         32'h0000_0000

`define ADC_CTL_DIFF         0
`define ADC_CTL_END          1
`define ADC_CTL_IE           2
`define ADC_CTL_TEMP         3

`define ADC_STAT_TAIL_LSB    0
`define ADC_STAT_HEAD_LSB    4
`define ADC_STAT_EMPTY       8
`define ADC_STAT_FULL        12

`define ADC_TRIG_PROCESSOR   4'h0
`define ADC_TRIG_ALWAYS      4'hf
`define ADC_TRIG_PERIPH_LAST 4'h4

`define ADC_AVG_MAX_SHIFT    3'h6
`define ADC_MID_CODE         10'h1ff
`define ADC_FULL_CODE        10'h3ff

`endif

// ---- logic/adc_seq_pkg.sv ----
// Types shared by the sequencer control block
package adc_seq_pkg;

  typedef struct packed {
    logic start;
    logic [3:0] pos_chan;
    logic [3:0] neg_chan;
    logic diff;
    logic temp;
  } conv_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_STORE = 4'b1000
  } seq_state_t;

  function automatic logic [3:0] seq_depth(input int s);
    case (s)
      0: seq_depth = 4'h8;
      1: seq_depth = 4'h4;
      2: seq_depth = 4'h4;
      default: seq_depth = 4'h1;
    endcase
  endfunction

endpackage

// ---- verification/adc_seq_ctrl_checker.sv ----
// Port-level assertions for the sequencer control block
`timescale 1ns/1ps
module adc_seq_ctrl_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // Converter and interrupts
  input wire adc_seq_pkg::conv_req_t conv_req_out,
  input wire logic conv_done_in,
  input wire logic [3:0] irq_out
);
  logic [3:0] act_r;
  logic [3:0] mask_r;
  logic [15:0] trig_r;
  logic [9:0] quiet_r;
  wire [3:0] proc_seq = {trig_r[15:12] == 4'h0, trig_r[11:8] == 4'h0, trig_r[7:4] == 4'h0, trig_r[3:0] == 4'h0};
  wire port_rd = rd_in && addr_in[4:0] == 5'h08 && addr_in[11:5] inside {7'h2, 7'h3, 7'h4, 7'h5};
  // Shadows of the control registers, kept from the bus traffic alone
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act_r <= 4'h0;
      mask_r <= 4'h0;
      trig_r <= 16'h0;
      quiet_r <= 10'h0;
    end else begin
      if (wr_in && addr_in == 12'h000) act_r <= wdata_in[3:0];
      if (wr_in && addr_in == 12'h008) mask_r <= wdata_in[3:0];
      if (wr_in && addr_in == 12'h014) trig_r <= wdata_in[15:0];
      // A run already under way may finish after disabling; each answer restarts the count
      if (act_r != 4'h0 || conv_done_in) quiet_r <= 10'h0;
      else if (quiet_r != 10'h3ff) quiet_r <= quiet_r + 10'h1;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  AST_RDATA_IDLE: assert property (
    !rd_in |=> rdata_out == 32'h0) else $error("Read data not cleared");
  AST_RESULT_WIDTH: assert property (
    port_rd |=> rdata_out[31:10] == 22'h0) else $error("Queue word upper bits set");
  AST_START_PULSE: assert property (
    conv_req_out.start |=> !conv_req_out.start) else $error("Start longer than one cycle");
  AST_DONE_GAP: assert property (
    conv_done_in |=> !conv_req_out.start) else $error("Start too soon after done");
  AST_DIFF_PAIR: assert property (
    conv_req_out.start && conv_req_out.diff |-> !conv_req_out.pos_chan[0] &&
    conv_req_out.neg_chan == conv_req_out.pos_chan + 4'h1) else $error("Bad differential pair");
  AST_CHAN_HOLD: assert property (
    !conv_req_out.start |-> $stable(conv_req_out[9:0])) else $error("Step fields moved without start");
  AST_IRQ_MASKED: assert property (
    (irq_out & ~$past(mask_r)) == 4'h0) else $error("Interrupt out while masked");
  AST_KICK_START: assert property (
    wr_in && addr_in == 12'h028 && (wdata_in[3:0] & act_r & proc_seq) != 4'h0 |-> ##[3:900] conv_req_out.start
  ) else $error("Kick did not start a conversion");
  AST_IDLE_QUIET: assert property (
    quiet_r == 10'h3ff |-> !conv_req_out.start) else $error("Start while all disabled");
endmodule // adc_seq_ctrl_checker

bind adc_seq_ctrl adc_seq_ctrl_checker i_checker (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .conv_req_out(conv_req_out),
  .conv_done_in(conv_done_in), .irq_out(irq_out));

// ---- verification/adc_conv_model.sv ----
// Behavioural converter core answering the sequencer's requests
`timescale 1ns/1ps
module adc_conv_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Requests and pacing
  input wire adc_seq_pkg::conv_req_t req_in,
  input wire logic slow_in,
  // Answer
  output logic done_out,
  output logic [9:0] data_out
);
  logic [3:0] wait_r;
  logic [9:0] code_r;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_r <= 4'h0;
      done_out <= 1'b0;
      data_out <= 10'h155;
    end else begin
      done_out <= 1'b0;
      // Code only valid with done; otherwise keep it moving
      data_out <= ~data_out;
      if (req_in.start) begin
        wait_r <= slow_in ? 4'h7 : 4'h1;
        code_r <= {req_in.diff, req_in.temp, req_in.pos_chan, 4'ha};
      end else if (wait_r == 4'h1) begin
        wait_r <= 4'h0;
        done_out <= 1'b1;
        data_out <= code_r;
      end else if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule // adc_conv_model

// ---- verification/adc_seq_ctrl_tb_top.sv ----
// Self-checking bench for the sequencer control block
`timescale 1ns/1ps
module adc_seq_ctrl_tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [3:0] periph_trig_in = 4'h0;
  logic slow = 1'b0;
  logic [31:0] rdata_out;
  adc_seq_pkg::conv_req_t conv_req_out;
  logic conv_done_in;
  logic [9:0] conv_data_in;
  logic [3:0] irq_out;
  int err_total = 0;
  int checks = 0;
  int starts = 0;
  logic [3:0] chan_q[$];
  logic [31:0] exp0[5] = '{32'h01a, 32'h03a, 32'h24a, 32'h17a, 32'h03a};
  always #10 clk_in = ~clk_in;
  adc_seq_ctrl i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .periph_trig_in(periph_trig_in),
    .conv_req_out(conv_req_out), .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .irq_out(irq_out));
  adc_conv_model i_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(conv_req_out), .slow_in(slow),
    .done_out(conv_done_in), .data_out(conv_data_in));
  always @(posedge clk_in) begin
    if (conv_req_out.start === 1'b1) begin
      starts++;
      chan_q.push_back(conv_req_out.pos_chan);
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    complete_run();
  end
  initial begin
    logic [31:0] d;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rc(12'h000, 32'h0);
    rc(12'h020, 32'h3210);
    rc(12'h030, 32'h0);
    rc(12'h0a4, 32'h2);
    rc(12'h024, 32'h0);
    for (int s = 0; s < 4; s++) begin
      rc(12'h04c + 12'(32 * s), 32'h100);
    end
    // One-step sequencer with its interrupt masked in
    wr(12'h0a0, 32'h5);
    wr(12'h0a4, 32'h6);
    wr(12'h008, 32'h8);
    wr(12'h000, 32'h8);
    wr(12'h028, 32'h8);
    repeat (30) @(posedge clk_in);
    check(32'(irq_out), 32'h8);
    rc(12'h004, 32'h8);
    rc(12'h00c, 32'h8);
    rc(12'h0a8, 32'h05a);
    wr(12'h00c, 32'h8);
    rc(12'h004, 32'h0);
    // Second result into a full queue is dropped
    wr(12'h028, 32'h8);
    repeat (30) @(posedge clk_in);
    wr(12'h028, 32'h8);
    repeat (30) @(posedge clk_in);
    rc(12'h010, 32'h8);
    rc(12'h0a8, 32'h05a);
    rd(12'h0a8, d);
    rc(12'h018, 32'h8);
    wr(12'h010, 32'h8);
    wr(12'h018, 32'h8);
    rc(12'h010, 32'h0);
    rc(12'h018, 32'h0);
    // Both runs above raised the raw bit of sequencer three
    wr(12'h00c, 32'h8);
    // Deep sequencer, end at step 4, repeated input, one differential pair, slow core
    slow <= 1'b1;
    wr(12'h040, 32'h0003_7231);
    wr(12'h044, 32'h0006_8140);
    wr(12'h000, 32'h1);
    wr(12'h028, 32'h1);
    repeat (120) @(posedge clk_in);
    rc(12'h04c, 32'h5);
    rc(12'h004, 32'h1);
    check(32'(irq_out), 32'h0);
    for (int i = 0; i < 5; i++) begin
      rc(12'h048, exp0[i]);
    end
    rc(12'h04c, 32'h155);
    // Two kicks at once go by priority value, not index
    slow <= 1'b0;
    wr(12'h020, 32'h2013);
    wr(12'h060, 32'h6);
    wr(12'h064, 32'h2);
    wr(12'h080, 32'h2);
    wr(12'h084, 32'h2);
    wr(12'h000, 32'h6);
    chan_q.delete();
    wr(12'h028, 32'h6);
    repeat (40) @(posedge clk_in);
    check(32'(chan_q[0]), 32'h2);
    check(32'(chan_q[1]), 32'h6);
    rc(12'h068, 32'h06a);
    rc(12'h088, 32'h02a);
    // Peripheral event on the first lane starts sequencer one
    wr(12'h014, 32'h10);
    periph_trig_in <= 4'h1;
    @(posedge clk_in);
    periph_trig_in <= 4'h0;
    repeat (30) @(posedge clk_in);
    rc(12'h068, 32'h06a);
    // Factor four: four conversions for one entry
    wr(12'h000, 32'h8);
    wr(12'h030, 32'h2);
    starts = 0;
    wr(12'h028, 32'h8);
    repeat (80) @(posedge clk_in);
    check(32'(starts), 32'h4);
    rc(12'h0a8, 32'h05a);
    wr(12'h030, 32'h0);
    // Always trigger re-runs the one-step sequencer, overflowing its queue, until it is disabled
    wr(12'h014, 32'hf000);
    repeat (40) @(posedge clk_in);
    wr(12'h000, 32'h0);
    repeat (10) @(posedge clk_in);
    rc(12'h0ac, 32'h1000);
    rc(12'h010, 32'h8);
    repeat (1100) @(posedge clk_in);
    complete_run();
  end
endmodule // adc_seq_ctrl_tb_top
